// ---- reclose_regs.svh ----
// register map, field positions, reset values and timing constants of the reclose sequencer
`ifndef RECLOSE_REGS_SVH
`define RECLOSE_REGS_SVH

// --------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------
`define REG_CONTROL     8'h00
`define REG_STATUS      8'h04
`define REG_SET_BASE    8'h40
`define REG_SET_COUNT   17
`define ADDR_LSB        2

// --------------------------------------------------------------
// setting slots (index into the setting array)
// --------------------------------------------------------------
`define SET_SPECIAL     5'h08
`define SET_DELAY       5'h09
`define SET_CB_WAIT     5'h0a
`define SET_SYNC_CHECK  5'h0b
`define SET_SYNC_SWITCH 5'h0c
`define SET_CLOSE       5'h0d
`define SET_RECLAIM     5'h0e
`define SET_MANUAL      5'h0f
`define SET_BLOCK_HOLD  5'h10
`define SET_THREE_BASE  3'h4

// --------------------------------------------------------------
// fields, reset values, responses
// --------------------------------------------------------------
`define CTL_DISABLE_3PH 0
`define SET_RESET       16'h0064
`define CYCLE_LAST      2'h3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// --------------------------------------------------------------
// timing: millisecond tick from the 100 MHz clock
// --------------------------------------------------------------
`define TICK_PERIOD_NS  1000000
`define CLK_PERIOD_NS   10

`endif

// ---- reclose_pkg.sv ----
// types shared by the reclose sequencer
package reclose_pkg;

	// sequencer states
	typedef enum logic [3:0] {
		st_idle,
		st_armed,
		st_delay,
		st_dead,
		st_cb_wait,
		st_sync_wait,
		st_sync_switch,
		st_close,
		st_reclaim,
		st_pickup_hold,
		st_blocked,
		st_manual_block
	} seq_state_t;

	// inputs from protection and user logic
	typedef struct packed {
		logic trip;
		logic all_phase;
		logic pickup;
		logic delay;
		logic first_zone;
		logic shorten;
		logic breaker_ready;
		logic sync_release;
		logic manual_close;
	} seq_in_t;

endpackage

// ---- reclose_sequencer.sv ----
// dead time, close and reclaim sequencer for automatic reclosing, with AXI4-Lite settings
//
// Functional notes
// R1 - dead time starts on start, held while delay
// R2 - start delay limited by configurable maximum
// R3 - eight dead times by cycle and trip type
// R4 - longer special first-cycle three-phase dead time
// R5 - shorten input ends dead time at once
// R6 - trip type selects single or three-phase
// R7 - three-phase once used stays for sequence
// R8 - three-phase trip with disable enters blocking
// R9 - close only with breaker ready, bounded wait
// R10 - breaker ready wait expiry enters blocking
// R11 - reclose only after sync release, bounded wait
// R12 - sync wait expiry starts switching, raises request
// R13 - switching wait expiry blocks and resets sequence
// R14 - one common close pulse of set length
// R15 - reclaim starts at close, outlasts close pulse
// R16 - fault in reclaim: next cycle, else reset
// R17 - pickup during reclaim keeps sequence alive
// R18 - manual close when idle: not ready period
// R19 - manual close during cycle blocks and resets
// R20 - blocking lasts set time, no close meanwhile
// R21 - start delay over maximum enters blocking
// R22 - any trip cuts close pulse short
// R23 - blocking only in cycle, status output high (code also raises the status in the manual-close period entered from idle)
// R24 - all timers count a common millisecond tick
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "reclose_regs.svh"

module reclose_sequencer
	import reclose_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int TW          = 16
)(
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// protection and user logic inputs
	input  wire logic        reclose_trip_start_in,
	input  wire logic        all_phase_trip_in,
	input  wire logic        protection_pickup_in,
	input  wire logic        dead_time_delay_in,
	input  wire logic        first_zone_fault_in,
	input  wire logic        shorten_dead_time_in,
	input  wire logic        breaker_ready_in,
	input  wire logic        sync_release_in,
	input  wire logic        manual_close_in,
	// sequencer outputs
	output logic             close_pulse_out,
	output logic             close_request_out,
	output logic             blocked_status_out
);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	seq_in_t raw_in;
	seq_in_t sync_a;
	seq_in_t in_s;

	assign raw_in = '{reclose_trip_start_in, all_phase_trip_in, protection_pickup_in,
		dead_time_delay_in, first_zone_fault_in, shorten_dead_time_in, breaker_ready_in,
		sync_release_in, manual_close_in};

	// two flops per input, first stage read only by the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a <= '0;
			in_s   <= '0;
		end
		else if (ce)
		begin
			sync_a <= raw_in;
			in_s   <= sync_a;
		end
	end

	// --------------------------------------------------------------
	// millisecond tick prescaler
	// --------------------------------------------------------------
	logic [31:0] pre;
	logic [31:0] next_pre;
	logic        tick;

	// common tick for every sequence timer
	always_comb
	begin
		next_pre = (pre >= 32'(TICK_CYCLES - 1)) ? '0 : pre + 32'h1; // R24
	end

	assign tick = (pre >= 32'(TICK_CYCLES - 1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre <= '0;
		else if (ce)
			pre <= next_pre;
	end

	// --------------------------------------------------------------
	// settings and control registers
	// --------------------------------------------------------------
	logic [TW-1:0] setting [`REG_SET_COUNT];
	logic          disable_3ph;

	logic          aw_full, w_full;
	logic          next_aw_full, next_w_full;
	logic [7:0]    aw_addr_q, next_aw_addr_q;
	logic [31:0]   w_data_q, next_w_data_q;
	logic [3:0]    w_strb_q, next_w_strb_q;
	logic          next_bvalid, next_rvalid;
	logic [1:0]    next_bresp, next_rresp;
	logic [31:0]   next_rdata;
	logic          wr_go;
	logic [5:0]    wr_idx, rd_idx;
	logic          wr_set, rd_set;

	assign wr_go  = aw_full && w_full && !bvalid;
	assign wr_idx = 6'(aw_addr_q[7:`ADDR_LSB] - 6'(`REG_SET_BASE >> `ADDR_LSB));
	assign rd_idx = 6'(araddr[7:`ADDR_LSB] - 6'(`REG_SET_BASE >> `ADDR_LSB));
	assign wr_set = (aw_addr_q >= `REG_SET_BASE) && (wr_idx < 6'(`REG_SET_COUNT));
	assign rd_set = (araddr >= `REG_SET_BASE) && (rd_idx < 6'(`REG_SET_COUNT));

	// one setting register per slot, low two byte lanes writable
	for (genvar i = 0; i < `REG_SET_COUNT; i++)
	begin : g_set
		logic [TW-1:0] next_val;
		always_comb
		begin
			next_val = setting[i];
			if (wr_go && wr_set && wr_idx == 6'(i))
			begin
				if (w_strb_q[0])
					next_val[7:0] = w_data_q[7:0];
				if (w_strb_q[1])
					next_val[TW-1:8] = w_data_q[TW-1:8];
			end
		end
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				setting[i] <= `SET_RESET;
			else if (ce)
				setting[i] <= next_val;
		end
	end

	// --------------------------------------------------------------
	// AXI4-Lite channel handling
	// --------------------------------------------------------------
	seq_state_t  state;
	logic [1:0]  cycle;
	logic        three_used;

	// address and data taken in either order, answer once both are held
	always_comb
	begin
		next_aw_full   = aw_full;
		next_w_full    = w_full;
		next_aw_addr_q = aw_addr_q;
		next_w_data_q  = w_data_q;
		next_w_strb_q  = w_strb_q;
		next_bvalid    = bvalid && !bready;
		next_bresp     = bresp;
		next_rvalid    = rvalid && !rready;
		next_rresp     = rresp;
		next_rdata     = rdata;
		if (awvalid && awready)
		begin
			next_aw_full   = 1'b1;
			next_aw_addr_q = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_full   = 1'b1;
			next_w_data_q = wdata;
			next_w_strb_q = wstrb;
		end
		if (wr_go)
		begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_set || aw_addr_q == `REG_CONTROL) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `RESP_OKAY;
			if (araddr == `REG_CONTROL)
				next_rdata = {31'h0, disable_3ph};
			else if (araddr == `REG_STATUS)
				next_rdata = {22'h0, blocked_status_out, close_request_out, close_pulse_out,
					three_used, cycle, 4'(state)};
			else if (rd_set)
				next_rdata = {16'h0, setting[rd_idx[4:0]]};
			else
			begin
				next_rdata = '0;
				next_rresp = `RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full     <= 1'b0;
			w_full      <= 1'b0;
			aw_addr_q   <= '0;
			w_data_q    <= '0;
			w_strb_q    <= '0;
			bvalid      <= 1'b0;
			bresp       <= `RESP_OKAY;
			rvalid      <= 1'b0;
			rresp       <= `RESP_OKAY;
			rdata       <= '0;
			awready     <= 1'b0;
			wready      <= 1'b0;
			arready     <= 1'b0;
			disable_3ph <= 1'b0;
		end
		else if (ce)
		begin
			aw_full   <= next_aw_full;
			w_full    <= next_w_full;
			aw_addr_q <= next_aw_addr_q;
			w_data_q  <= next_w_data_q;
			w_strb_q  <= next_w_strb_q;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rresp     <= next_rresp;
			rdata     <= next_rdata;
			awready   <= !next_aw_full;
			wready    <= !next_w_full;
			arready   <= !next_rvalid && !(arvalid && arready);
			if (wr_go && aw_addr_q == `REG_CONTROL && w_strb_q[0])
				disable_3ph <= w_data_q[`CTL_DISABLE_3PH];
		end
	end

	// --------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------
	seq_state_t    next_state;
	logic [1:0]    next_cycle;
	logic          next_three_used;
	logic          pickup_seen, next_pickup_seen;
	logic [TW-1:0] cnt, next_cnt;
	logic [TW-1:0] rc, next_rc;
	logic [TW-1:0] dead_len;
	logic          running;
	logic          three_now;

	assign three_now = three_used || in_s.all_phase;
	assign running   = !(state inside {st_idle, st_blocked, st_manual_block});

	// dead time by cycle and trip type, special value for a first-zone fault in the first cycle when three-phase
	always_comb
	begin
		if (three_used && cycle == 2'h0 && in_s.first_zone)
			dead_len = setting[`SET_SPECIAL];                       // R4
		else if (three_used)
			dead_len = setting[5'(`SET_THREE_BASE) + 5'(cycle)];   // R3 R6 R7
		else
			dead_len = setting[{3'h0, cycle}];                      // R3 R6
	end

	// state transitions and sequence bookkeeping
	always_comb
	begin
		next_state       = state;
		next_cycle       = cycle;
		next_three_used  = three_used;
		next_pickup_seen = pickup_seen;
		unique case (state)
			st_idle:
			begin
				if (in_s.manual_close)
					next_state = st_manual_block;                   // R18
				else if (in_s.trip)
				begin
					next_cycle      = 2'h0;
					next_three_used = in_s.all_phase;               // R6
					next_state      = (in_s.all_phase && disable_3ph) ? st_blocked : st_armed; // R8
				end
			end
			st_armed:
			begin
				if (!in_s.trip)
					next_state = in_s.delay ? st_delay : st_dead;   // R1
			end
			st_delay:
			begin
				if (cnt > setting[`SET_DELAY])
					next_state = st_blocked;                        // R2 R21
				else if (!in_s.delay)
					next_state = st_dead;                           // R1
			end
			st_dead:
			begin
				if (in_s.shorten || cnt > dead_len)
					next_state = st_cb_wait;                        // R5
			end
			st_cb_wait:
			begin
				if (in_s.breaker_ready)
					next_state = st_sync_wait;                      // R9
				else if (cnt > setting[`SET_CB_WAIT])
					next_state = st_blocked;                        // R10
			end
			st_sync_wait:
			begin
				if (in_s.sync_release)
					next_state = st_close;                          // R11
				else if (cnt > setting[`SET_SYNC_CHECK])
					next_state = st_sync_switch;                    // R12
			end
			st_sync_switch:
			begin
				if (in_s.sync_release)
					next_state = st_close;
				else if (cnt > setting[`SET_SYNC_SWITCH])
					next_state = st_blocked;                        // R13
			end
			st_close:
			begin
				next_pickup_seen = 1'b0;
				if (in_s.trip || cnt > setting[`SET_CLOSE])
					next_state = st_reclaim;                        // R14 R22
			end
			st_reclaim:
			begin
				if (in_s.pickup)
					next_pickup_seen = 1'b1;                        // R17
				if (in_s.trip)
				begin
					if (cycle == `CYCLE_LAST)
						next_state = st_blocked;
					else
					begin
						next_cycle      = cycle + 2'h1;             // R16
						next_three_used = three_now;                // R7
						next_state      = (in_s.all_phase && disable_3ph) ? st_blocked : st_armed;
					end
				end
				else if (rc > setting[`SET_RECLAIM])
					next_state = (pickup_seen || in_s.pickup) ? st_pickup_hold : st_idle; // R15 R16
			end
			st_pickup_hold:
			begin
				if (in_s.trip && cycle != `CYCLE_LAST)
				begin
					next_cycle      = cycle + 2'h1;                 // R17
					next_three_used = three_now;
					next_state      = (in_s.all_phase && disable_3ph) ? st_blocked : st_armed;
				end
				else if (in_s.trip)
					next_state = st_blocked;
				else if (!in_s.pickup)
					next_state = st_idle;
			end
			st_blocked:
			begin
				if (cnt > setting[`SET_BLOCK_HOLD])
					next_state = st_idle;                           // R20
			end
			st_manual_block:
			begin
				if (in_s.trip)
					next_state = st_blocked;
				else if (cnt > setting[`SET_MANUAL])
					next_state = st_idle;                           // R18
			end
		endcase
		// manual close overrides any running cycle
		if (running && in_s.manual_close)
			next_state = st_blocked;                                // R19
		if (next_state == st_idle || next_state == st_blocked)
		begin
			next_cycle      = 2'h0;                                 // R13 R19
			next_three_used = 1'b0;
		end
	end

	// per-state millisecond counter, reclaim counter runs from the close onward
	// a limit of L ms expires once the count passes L, so no wait is ever cut short
	always_comb
	begin
		if (next_state != state)
			next_cnt = '0;
		else
			next_cnt = (tick && cnt != '1) ? cnt + 1'b1 : cnt;      // R24
		if (next_state == st_close && state != st_close)
			next_rc = '0;                                           // R15
		else if ((state == st_close || state == st_reclaim) && tick && rc != '1)
			next_rc = rc + 1'b1;
		else
			next_rc = rc;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state              <= st_idle;
			cycle              <= 2'h0;
			three_used         <= 1'b0;
			pickup_seen        <= 1'b0;
			cnt                <= '0;
			rc                 <= '0;
			close_pulse_out    <= 1'b0;
			close_request_out  <= 1'b0;
			blocked_status_out <= 1'b0;
		end
		else if (ce)
		begin
			state              <= next_state;
			cycle              <= next_cycle;
			three_used         <= next_three_used;
			pickup_seen        <= next_pickup_seen;
			cnt                <= next_cnt;
			rc                 <= next_rc;
			close_pulse_out    <= (next_state == st_close);         // R14 R20
			close_request_out  <= (next_state == st_sync_switch);   // R12
			blocked_status_out <= (next_state == st_blocked || next_state == st_manual_block); // R23
		end
	end

endmodule

// ---- reclose_sequencer_assertions.sv ----
// port-level checks of the reclose sequencer, bound into the design
`timescale 1ns/1ps

module reclose_sequencer_assertions (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched inputs
	input wire logic reclose_trip_start_in,
	input wire logic sync_release_in,
	input wire logic manual_close_in,
	// watched outputs
	input wire logic close_pulse_out,
	input wire logic close_request_out,
	input wire logic blocked_status_out
);
	default clocking dflt @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------
	// output relations
	// ----------------------------
	chk_no_close_blocked: assert property (close_pulse_out |-> !blocked_status_out)
		else $error("close while blocked");
	chk_req_not_close: assert property (close_request_out |-> !close_pulse_out)
		else $error("request and close together");
	chk_release_gates: assert property ($rose(close_pulse_out) |->
		$past(sync_release_in, 2) || $past(sync_release_in, 3) || $past(sync_release_in, 4))
		else $error("close without sync release");
	chk_trip_cuts: assert property ($rose(reclose_trip_start_in) && close_pulse_out |->
		##[1:5] !close_pulse_out)
		else $error("trip did not cut close");
	chk_req_ends: assert property ($fell(close_request_out) |->
		##[0:2] (close_pulse_out || blocked_status_out))
		else $error("request ended without close or block");
	chk_manual_blocks: assert property ($rose(manual_close_in) |-> ##[2:6] blocked_status_out)
		else $error("manual close not blocking");
	chk_close_after_fall: assert property ($rose(close_pulse_out) |->
		!$past(reclose_trip_start_in, 3))
		else $error("close while trip still high");
	chk_req_no_release: assert property ($rose(close_request_out) |->
		!$past(sync_release_in, 3) || !$past(sync_release_in, 4))
		else $error("request despite release");

	// main scenarios reached
	cov_close: cover property ($rose(close_pulse_out));
	cov_request: cover property ($rose(close_request_out));
	cov_blocked: cover property ($rose(blocked_status_out));
endmodule

bind reclose_sequencer reclose_sequencer_assertions chk (.aclk, .aresetn, .reclose_trip_start_in,
	.sync_release_in, .manual_close_in, .close_pulse_out, .close_request_out, .blocked_status_out);

// ---- reclose_partner.sv ----
// far side model: breaker readiness, start delay source and synchro-check answer
`timescale 1ns/1ps

module reclose_partner (
	// clock and watched pins
	input wire logic        aclk,
	input wire logic        reclose_trip_start_in,
	input wire logic        close_request_out,
	// behaviour, in clock cycles
	input wire logic [15:0] cb_lag,
	input wire logic [15:0] sw_lag,
	input wire logic [15:0] dly,
	input wire logic        sync_ok,
	// answers toward the sequencer
	output logic            breaker_ready_in,
	output logic            sync_release_in,
	output logic            dead_time_delay_in
);
	int   fc = 1000;
	int   rc = 0;
	logic tp = 1'h0;

	initial
	begin
		breaker_ready_in = 1'h1;
		sync_release_in = 1'h1;
		dead_time_delay_in = 1'h0;
	end

	// breaker opens on trip and recharges for cb_lag cycles after the trip falls
	always @(posedge aclk)
	begin
		tp <= reclose_trip_start_in;
		fc <= (tp && !reclose_trip_start_in) ? 0 : fc + 1;
		rc <= close_request_out ? rc + 1 : 0;
		breaker_ready_in <= !reclose_trip_start_in && !tp && fc >= cb_lag;
		dead_time_delay_in <= dly > 0 && (reclose_trip_start_in || tp || fc < dly);
		sync_release_in <= sync_ok || (close_request_out && rc >= sw_lag);
	end
endmodule

// ---- autoreclose_dead_time_close_sequencer_bench.sv ----
// self-checking bench of the reclose sequencer
`timescale 1ns/1ps
`include "reclose_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end

module autoreclose_dead_time_close_sequencer_bench;
	localparam int T = 10;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        reclose_trip_start_in = 1'h0, all_phase_trip_in = 1'h0, protection_pickup_in = 1'h0;
	logic        first_zone_fault_in = 1'h0, shorten_dead_time_in = 1'h0, manual_close_in = 1'h0;
	logic        breaker_ready_in, sync_release_in, dead_time_delay_in;
	logic        close_pulse_out, close_request_out, blocked_status_out;
	logic        sync_ok = 1'h1, mc = 1'h0, cut = 1'h0, m3 = 1'h0;
	logic [15:0] cb_lag = 16'h0, sw_lag = 16'h0, dly = 16'h0;
	logic [31:0] seed = 32'h143a7;
	int          st[17] = '{3, 7, 11, 15, 19, 23, 27, 31, 35, 5, 4, 3, 4, 2, 6, 5, 5};
	int          m_cyc = 0, tn = 0, cycles = 0, num_errors = 0, samples_checked = 0;

	// --------------------------
	// design, far side, clock
	// --------------------------
	reclose_sequencer #(.TICK_CYCLES(T)) uut (.aclk, .aresetn, .ce(1'h1), .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .reclose_trip_start_in, .all_phase_trip_in,
		.protection_pickup_in, .dead_time_delay_in, .first_zone_fault_in, .shorten_dead_time_in,
		.breaker_ready_in, .sync_release_in, .manual_close_in, .close_pulse_out,
		.close_request_out, .blocked_status_out);
	reclose_partner far (.aclk, .reclose_trip_start_in, .close_request_out, .cb_lag, .sw_lag, .dly,
		.sync_ok, .breaker_ready_in, .sync_release_in, .dead_time_delay_in);
	always #5 aclk = ~aclk;

	// hang guard
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// --------------------------
	// helpers and model
	// --------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected dead time in ms from cycle number and trip kind
	function int model_dead(input logic a);
		m3 |= a;
		if (m3 && m_cyc == 0 && first_zone_fault_in === 1'h1)
			return st[8];
		return st[(m3 ? 4 : 0) + m_cyc];
	endfunction

	task report_and_stop();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw;
		ta = 0;
		tw = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (awready && !ta)
				awvalid <= 1'h0;
			if (wready && !tw)
				wvalid <= 1'h0;
			ta |= awready;
			tw |= wready;
		end
		do @(posedge aclk); while (!bvalid);
		`CHK(bresp, r)
		bready <= 1'h0;
		@(posedge aclk);
	endtask

	// one read, data and response compared
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		`CHK(rdata, d)
		`CHK(rresp, r)
		rready <= 1'h0;
		@(posedge aclk);
	endtask

	// back in idle with no cycle or flag left
	task idle_chk();
		repeat (100) @(posedge aclk);
		rd(`REG_STATUS, 32'h0, `RESP_OKAY);
		m_cyc = 0;
		m3 = 0;
		tn++;
		$display("test %0d done", tn);
	endtask

	// wait for blocked status, then time how long it stands
	task wait_blk();
		int n;
		n = 0;
		while (!blocked_status_out && n < 900)
		begin
			@(posedge aclk);
			n++;
		end
		manual_close_in <= 1'h0;
		`CHK(blocked_status_out, 1'h1)
		`CHK(close_pulse_out, 1'h0)
		n = 0;
		while (blocked_status_out && n < 900)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK(n >= 5 * T && n <= 6 * T + 4, 1'h1)
		idle_chk();
	endtask

	// one fault: trip, release, then close or blocking
	task shot(input logic a, input int extra, input logic blk);
		int n, e, k;
		logic rq;
		rq = 0;
		k = 15 + int'(rnd() % 16);
		all_phase_trip_in <= a;
		reclose_trip_start_in <= 1'h1;
		n = 0;
		// a trip that blocks at once is dropped there, so the whole blocking time is seen
		while (n < k && !blocked_status_out)
		begin
			@(posedge aclk);
			n++;
		end
		// model read after the edges, once level inputs set before the call have settled
		e = model_dead(a) + extra;
		if (shorten_dead_time_in === 1'h1)
			e = extra;
		reclose_trip_start_in <= 1'h0;
		protection_pickup_in <= 1'h0;
		n = 0;
		while (!close_pulse_out && !blocked_status_out && n < 900)
		begin
			@(posedge aclk);
			n++;
			rq |= close_request_out;
			if (n == 5 && mc)
				manual_close_in <= 1'h1;
		end
		if (blk)
			wait_blk();
		else if (cut)
		begin
			reclose_trip_start_in <= 1'h1;
			repeat (6) @(posedge aclk);
			`CHK(close_pulse_out, 1'h0)
		end
		else
		begin
			`CHK(n >= e * T && n <= (e + 2) * T + 12, 1'h1)
			`CHK(rq, !sync_ok)
			m_cyc++;
			n = 0;
			while (close_pulse_out && n < 900)
			begin
				@(posedge aclk);
				n++;
			end
			`CHK(n >= 2 * T && n <= 3 * T + 2, 1'h1)
		end
	endtask

	// --------------------------
	// main sequence
	// --------------------------
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rd(`REG_SET_BASE, 32'(`SET_RESET), `RESP_OKAY);
		rd(`REG_CONTROL, 32'h0, `RESP_OKAY);
		rd(8'h84, 32'h0, `RESP_SLVERR);
		wr(8'h84, rnd(), `RESP_SLVERR);
		for (int i = 0; i < 17; i++)
			wr(`REG_SET_BASE + 8'(4 * i), 32'(st[i]), `RESP_OKAY);
		rd(`REG_SET_BASE + 8'h1c, 32'(st[7]), `RESP_OKAY);
		// four shots with faults in reclaim, three-phase from the third on, then lockout
		shot(0, 0, 0);
		shot(0, 0, 0);
		shot(1, 0, 0);
		shot(0, 0, 0);
		shot(0, 0, 1);
		// success, restart at cycle one, pickup carried past reclaim
		shot(0, 0, 0);
		idle_chk();
		shot(0, 0, 0);
		protection_pickup_in <= 1'h1;
		repeat (90) @(posedge aclk);
		shot(0, 0, 0);
		idle_chk();
		// special first-cycle and shortened dead time
		first_zone_fault_in <= 1'h1;
		shot(1, 0, 0);
		first_zone_fault_in <= 1'h0;
		idle_chk();
		shorten_dead_time_in <= 1'h1;
		shot(0, 0, 0);
		shorten_dead_time_in <= 1'h0;
		idle_chk();
		// start delay within and beyond its limit
		dly <= 16'h14;
		shot(0, 2, 0);
		idle_chk();
		dly <= 16'h50;
		shot(0, 0, 1);
		dly <= 16'h0;
		// three-phase reclose disabled
		wr(`REG_CONTROL, 32'h1, `RESP_OKAY);
		shot(1, 0, 1);
		wr(`REG_CONTROL, 32'h0, `RESP_OKAY);
		// breaker late, then ready only after its wait has expired
		cb_lag <= 16'h32;
		shot(0, 2, 0);
		idle_chk();
		cb_lag <= 16'h96;
		shot(0, 0, 1);
		cb_lag <= 16'h0;
		// synchronous switching succeeds, then times out
		sync_ok <= 1'h0;
		sw_lag <= 16'ha;
		shot(0, 4, 0);
		idle_chk();
		sw_lag <= 16'hc8;
		shot(0, 0, 1);
		sync_ok <= 1'h1;
		// manual close in a cycle and in idle
		mc <= 1'h1;
		shot(0, 0, 1);
		mc <= 1'h0;
		manual_close_in <= 1'h1;
		wait_blk();
		// trip during the close pulse
		cut <= 1'h1;
		shot(0, 0, 0);
		report_and_stop();
	end
endmodule
